// ---- inc/rmd_pkg.sv ----
// constants, states and state record of the radix-4 integer multiply/divide unit
package rmd_pkg;

    // ----------------------------------------------------------------
    // datapath widths
    // ----------------------------------------------------------------
    localparam int unsigned OP_W        = 32;
    localparam int unsigned ACC_W       = 57;
    localparam int unsigned RB_W        = 56;
    localparam int unsigned SUM_W       = 58;
    localparam int unsigned LOW_W       = 34;
    localparam int unsigned MPL_SHIFT_W = 30;
    localparam int unsigned SH_W        = 5;
    localparam int unsigned CNT_W       = 6;
    localparam int unsigned DIGIT_W     = 2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned RB_OP_LSB    = 23;
    localparam int unsigned RB_OP_MSB    = 54;
    localparam int unsigned OVF_HI       = 52;
    localparam int unsigned OVF_LO       = 21;
    localparam int unsigned OVF_REF      = 20;
    localparam int unsigned LOW_PROD_LSB = 23;
    localparam int unsigned REM_ALIGN    = 25;
    localparam int unsigned DIV_REM_TOP  = 54;

    // ----------------------------------------------------------------
    // loop counts
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_ZERO       = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE        = 6'h01;
    localparam logic [CNT_W-1:0] MUL_LAST_CLOCK = 6'h1f;
    localparam logic [CNT_W-1:0] DIV_ITER_BASE  = 6'h10;
    localparam logic [SH_W-1:0]  SH_MAX         = 5'h1f;

    // ----------------------------------------------------------------
    // sequencer states, gray along the multiply path
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_MUL_LOOP = 3'h1,
        ST_MUL_FIX  = 3'h3,
        ST_PRESENT  = 3'h2,
        ST_DIV_LOOP = 3'h6,
        ST_REM_FIX  = 3'h7
    } rmd_state_e;

    typedef struct packed {
        rmd_state_e             state;
        logic [CNT_W-1:0]       cnt;
        logic [ACC_W-1:0]       partial_accum_reg;
        logic [RB_W-1:0]        divisor_multiplicand_reg;
        logic [MPL_SHIFT_W-1:0] multiplier_shift_reg;
        logic [LOW_W-1:0]       low_result_shift_reg;
        logic                   estimate_bit_low;
        logic                   estimate_bit_high;
        logic [SH_W-1:0]        norm_shift_length;
        logic                   a_neg;
        logic                   b_neg;
        logic [OP_W-1:0]        res_high;
        logic [OP_W-1:0]        res_low;
        logic                   overflow_flag;
    } rmd_regs_s;

endpackage

// ---- rtl/rmd_shift_matrix.sv ----
// left-shift matrix with optional bit reversal around it, giving a right shift
`timescale 1ns/1ns
`default_nettype none

module rmd_shift_matrix
    import rmd_pkg::*;
#(
    parameter int unsigned W = 32
) (
    input  wire logic [W-1:0]    data_in,
    input  wire logic [SH_W-1:0] amount,
    input  wire logic            reverse,
    output logic      [W-1:0]    data_out
);

    logic [W-1:0] pre;
    logic [W-1:0] shifted;

    // no right shifter exists: reversing in and out turns the left shift round
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pre[i] = reverse ? data_in[W-1-i] : data_in[i];
        end
        shifted = pre << amount;
        for (int i = 0; i < W; i++) begin
            data_out[i] = reverse ? shifted[W-1-i] : shifted[i];
        end
    end

endmodule

`default_nettype wire

// ---- rtl/rmd_mul_div.sv ----
// radix-4 signed 32-bit integer multiply and divide datapath with its sequencer
// How it works
// - multiplier pair picks 0..3 times, add, shift two
// - three times comes from adder of 1x and 2x
// - multiplicand loaded at bits 54..23, sign-extended
// - load multiplier 31..2, clear accumulator, route low pair
// - multiply loop is 32 clocks, 16 iterations
// - two low adder bits shift into low extension
// - negative multiplier: subtract multiplicand once, shift two
// - final cycle drives result lines
// - overflow unless product bits 52..20 all equal
// - priority encoder normalizes divisor to bit 54
// - negate divisor first, then hold it steady
// - odd shift count moves dividend left one place
// - dividend made positive by set-up negator a_mag, loaded shifted
// - estimate from full compares of remainder with 1x and 2x divisor
// - primary subtracts estimate, alternate one multiple less
// - primary carry picks which difference reloads accumulator
// - quotient pair is estimate or estimate minus one
// - estimate codes select 1/0, 2/1, 3/2 multiples
// - remainder shifted back via reversed left shifter
// - quotient negated when operand signs differ
// - remainder negated when dividend was negative
// - ready pulse once result is on lines
`timescale 1ns/1ns
`default_nettype none

module rmd_mul_div
    import rmd_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic            start_multiply,
    input  wire logic            start_divide,
    input  wire logic [OP_W-1:0] operand_a,
    input  wire logic [OP_W-1:0] operand_b,
    output logic      [OP_W-1:0] result_high,
    output logic      [OP_W-1:0] result_low,
    output logic                 overflow_flag,
    output logic                 result_ready_pulse,
    output logic                 busy
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    rmd_regs_s r;
    rmd_regs_s next_r;

    // ----------------------------------------------------------------
    // divide set-up: magnitudes, priority encoder, normalizer
    // ----------------------------------------------------------------
    logic [OP_W-1:0]  a_mag;
    logic [OP_W-1:0]  b_mag;
    logic [SH_W-1:0]  msb_pos;
    logic [SH_W-1:0]  sh_calc;
    logic [OP_W-1:0]  norm_divisor;
    logic [LOW_W-1:0] dividend_stage;
    logic             divisor_zero;
    logic [ACC_W-1:0] rem_shifted;

    always_comb begin
        a_mag = operand_a[OP_W-1] ? OP_W'(32'h0 - operand_a) : operand_a;
        b_mag = operand_b[OP_W-1] ? OP_W'(32'h0 - operand_b) : operand_b;
        msb_pos = '0;
        for (int i = 0; i < OP_W; i++) begin
            if (b_mag[i]) begin
                msb_pos = SH_W'(i);
            end
        end
        sh_calc = SH_MAX - msb_pos;
        divisor_zero = (b_mag == '0);
        // the staged word keeps the bit an odd alignment would push out
        dividend_stage = {a_mag, 2'h0} >> (sh_calc[0] ? 1 : 2);
    end

    rmd_shift_matrix #(
        .W (OP_W)
    ) u_norm (
        .data_in  (b_mag),
        .amount   (sh_calc),
        .reverse  (1'b0),
        .data_out (norm_divisor)
    );

    rmd_shift_matrix #(
        .W (ACC_W)
    ) u_rem_back (
        .data_in  (r.partial_accum_reg),
        .amount   (r.norm_shift_length),
        .reverse  (1'b1),
        .data_out (rem_shifted)
    );

    // ----------------------------------------------------------------
    // adders and divisor multiples
    // ----------------------------------------------------------------
    logic [SUM_W-1:0] acc_ext;
    logic [SUM_W-1:0] rb_x1;
    logic [SUM_W-1:0] rb_x2;
    logic [SUM_W-1:0] rb_x3;
    logic [SUM_W-1:0] mul_pick;
    logic [SUM_W-1:0] y_pick;
    logic [SUM_W-1:0] x_pick;
    logic [SUM_W-1:0] y_sum;
    logic [SUM_W-1:0] x_sum;
    logic             primary_adder_carry;
    logic             est_low;
    logic             est_high;
    logic [DIGIT_W-1:0] est_digit;
    logic [DIGIT_W-1:0] q_digit;

    always_comb begin
        acc_ext = {(r.partial_accum_reg[ACC_W-1] & ~(r.state == ST_DIV_LOOP)),
                   r.partial_accum_reg};
        rb_x1 = {{(SUM_W-RB_W){r.divisor_multiplicand_reg[RB_W-1]}}, r.divisor_multiplicand_reg};
        rb_x2 = rb_x1 << 1;
        rb_x3 = rb_x1 + rb_x2;

        case ({r.estimate_bit_high, r.estimate_bit_low})
            2'h0:    mul_pick = '0;
            2'h1:    mul_pick = rb_x1;
            2'h2:    mul_pick = rb_x2;
            2'h3:    mul_pick = rb_x3;
            default: mul_pick = '0;
        endcase

        // estimate against the whole remainder and divisor multiples
        // full compares keep the pick within one of the true digit
        est_high = (acc_ext >= rb_x2);
        est_low  = ~est_high & (acc_ext >= rb_x1);
        if (est_high) begin
            y_pick    = rb_x3;
            x_pick    = rb_x2;
            est_digit = 2'h3;
        end else if (est_low) begin
            y_pick    = rb_x2;
            x_pick    = rb_x1;
            est_digit = 2'h2;
        end else begin
            y_pick    = rb_x1;
            x_pick    = '0;
            est_digit = 2'h1;
        end
        y_sum = acc_ext - y_pick;
        x_sum = acc_ext - x_pick;
        primary_adder_carry = ~y_sum[SUM_W-1];
        q_digit = primary_adder_carry ? est_digit : DIGIT_W'(est_digit - 2'h1);
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    logic [SUM_W-1:0] m_sum;
    logic [ACC_W-1:0] m_acc;
    logic [LOW_W-1:0] m_low;
    logic [OP_W-1:0]  rem_mag;
    logic [OP_W-1:0]  quo_mag;

    always_comb begin
        next_r  = r;
        m_sum   = acc_ext;
        m_acc   = '0;
        m_low   = '0;
        rem_mag = rem_shifted[REM_ALIGN+OP_W-1:REM_ALIGN];
        quo_mag = r.low_result_shift_reg[OP_W-1:0];

        case (r.state)
            ST_IDLE: begin
                // operands are taken on the start edge itself
                if (start_multiply) begin
                    next_r.divisor_multiplicand_reg =
                        {{(RB_W-RB_OP_MSB-1){operand_b[OP_W-1]}}, operand_b, {RB_OP_LSB{1'b0}}};
                    next_r.multiplier_shift_reg = operand_a[OP_W-1:DIGIT_W];
                    next_r.estimate_bit_low     = operand_a[0];
                    next_r.estimate_bit_high    = operand_a[1];
                    next_r.partial_accum_reg    = '0;
                    next_r.low_result_shift_reg = '0;
                    next_r.a_neg                = operand_a[OP_W-1];
                    next_r.cnt                  = CNT_ZERO;
                    next_r.state                = ST_MUL_LOOP;
                end else if (start_divide) begin
                    next_r.a_neg                = operand_a[OP_W-1];
                    next_r.b_neg                = operand_b[OP_W-1];
                    next_r.norm_shift_length    = sh_calc;
                    next_r.divisor_multiplicand_reg =
                        {{(RB_W-RB_OP_MSB-1){1'b0}}, norm_divisor, {RB_OP_LSB{1'b0}}};
                    next_r.partial_accum_reg    = {dividend_stage, {RB_OP_LSB{1'b0}}};
                    next_r.low_result_shift_reg = '0;
                    next_r.cnt = DIV_ITER_BASE - CNT_W'(msb_pos[SH_W-1:1]);
                    if (divisor_zero) begin
                        next_r.overflow_flag = 1'b1;
                        next_r.res_high      = '0;
                        next_r.res_low       = '0;
                        next_r.state         = ST_PRESENT;
                    end else begin
                        next_r.state = ST_DIV_LOOP;
                    end
                end
            end

            ST_MUL_LOOP: begin
                // two clocks per iteration; the sum is taken on the odd one
                next_r.cnt = CNT_W'(r.cnt + CNT_ONE);
                if (r.cnt[0]) begin
                    m_sum = acc_ext + mul_pick;
                    next_r.partial_accum_reg = {m_sum[SUM_W-1], m_sum[SUM_W-1:DIGIT_W]};
                    next_r.low_result_shift_reg =
                        {m_sum[DIGIT_W-1:0], r.low_result_shift_reg[LOW_W-1:DIGIT_W]};
                    next_r.estimate_bit_low     = r.multiplier_shift_reg[0];
                    next_r.estimate_bit_high    = r.multiplier_shift_reg[1];
                    next_r.multiplier_shift_reg = r.multiplier_shift_reg >> DIGIT_W;
                end
                if (r.cnt == MUL_LAST_CLOCK) begin
                    next_r.state = ST_MUL_FIX;
                end
            end

            ST_MUL_FIX: begin
                m_sum = r.a_neg ? SUM_W'(acc_ext - rb_x1) : acc_ext;
                m_acc = {m_sum[SUM_W-1], m_sum[SUM_W-1:DIGIT_W]};
                m_low = {m_sum[DIGIT_W-1:0], r.low_result_shift_reg[LOW_W-1:DIGIT_W]};
                next_r.partial_accum_reg    = m_acc;
                next_r.low_result_shift_reg = m_low;
                next_r.res_high = m_acc[OVF_HI:OVF_LO];
                next_r.res_low  = {m_acc[OVF_REF:0], m_low[LOW_W-1:LOW_PROD_LSB]};
                next_r.overflow_flag = |(m_acc[OVF_HI:OVF_LO] ^ {OP_W{m_acc[OVF_REF]}});
                next_r.state = ST_PRESENT;
            end

            ST_DIV_LOOP: begin
                // divisor register is left untouched throughout the loop
                if (primary_adder_carry) begin
                    next_r.partial_accum_reg = {y_sum[DIV_REM_TOP:0], 2'h0};
                end else begin
                    next_r.partial_accum_reg = {x_sum[DIV_REM_TOP:0], 2'h0};
                end
                next_r.low_result_shift_reg =
                    {r.low_result_shift_reg[LOW_W-DIGIT_W-1:0], q_digit};
                next_r.cnt = CNT_W'(r.cnt - CNT_ONE);
                if (r.cnt == CNT_ONE) begin
                    next_r.state = ST_REM_FIX;
                end
            end

            ST_REM_FIX: begin
                next_r.res_low  = (r.a_neg ^ r.b_neg) ? OP_W'(32'h0 - quo_mag) : quo_mag;
                next_r.res_high = r.a_neg ? OP_W'(32'h0 - rem_mag) : rem_mag;
                next_r.overflow_flag = 1'b0;
                next_r.state = ST_PRESENT;
            end

            ST_PRESENT: begin
                next_r.state = ST_IDLE;
            end

            default: begin
                next_r.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs to the host
    // ----------------------------------------------------------------
    assign result_high        = r.res_high;
    assign result_low         = r.res_low;
    assign overflow_flag      = r.overflow_flag;
    assign result_ready_pulse = (r.state == ST_PRESENT);
    assign busy               = (r.state != ST_IDLE);

endmodule

`default_nettype wire

// ---- sim/rmd_host_model.sv ----
// host-side model: raises a start with its operands and holds both until taken
`timescale 1ns/1ns
`default_nettype none

module rmd_host_model
    import rmd_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic            go,
    input  wire logic            is_div,
    input  wire logic [OP_W-1:0] a_in,
    input  wire logic [OP_W-1:0] b_in,
    input  wire logic            busy,
    output logic                 start_multiply,
    output logic                 start_divide,
    output logic      [OP_W-1:0] operand_a,
    output logic      [OP_W-1:0] operand_b
);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            start_multiply <= 1'b0;
            start_divide   <= 1'b0;
            operand_a      <= '0;
            operand_b      <= '0;
        end else if (go) begin
            start_multiply <= !is_div;
            start_divide   <= is_div;
            operand_a      <= a_in;
            operand_b      <= b_in;
        end else if ((start_multiply || start_divide) && !busy) begin
            // taken here; released lines must not keep showing the old operands
            start_multiply <= 1'b0;
            start_divide   <= 1'b0;
            operand_a      <= ~operand_a;
            operand_b      <= ~operand_b;
        end
    end
endmodule

`default_nettype wire

// ---- sim/rmd_mul_div_sva.sv ----
// concurrent checks on the multiply/divide unit's host ports
`timescale 1ns/1ns
`default_nettype none

module rmd_mul_div_sva
    import rmd_pkg::*;
(
    input wire logic            sys_clk,
    input wire logic            reset,
    input wire logic            start_multiply,
    input wire logic            start_divide,
    input wire logic [OP_W-1:0] operand_a,
    input wire logic [OP_W-1:0] operand_b,
    input wire logic [OP_W-1:0] result_high,
    input wire logic [OP_W-1:0] result_low,
    input wire logic            overflow_flag,
    input wire logic            result_ready_pulse,
    input wire logic            busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic op_div;
    logic a_neg;
    // the outputs alone cannot tell which operation finished
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            op_div <= 1'b0;
            a_neg  <= 1'b0;
        end else if (!busy && (start_multiply || start_divide)) begin
            op_div <= !start_multiply;
            a_neg  <= operand_a[OP_W-1];
        end
    end

    sequence take_mul_s;
        !busy && start_multiply;
    endsequence
    sequence take_div_s;
        !busy && start_divide && !start_multiply;
    endsequence

    mul_latency_a: assert property (take_mul_s |-> ##34 result_ready_pulse)
        else $error("multiply ready not at its fixed cycle");
    mul_early_a: assert property (take_mul_s |=> !result_ready_pulse [*8])
        else $error("multiply ready too early");
    div_zero_a: assert property (take_div_s ##0 (operand_b == '0) |-> ##1
        (result_ready_pulse && overflow_flag && result_low == '0 && result_high == '0))
        else $error("divide by zero answer wrong");
    div_span_a: assert property (take_div_s ##0 (operand_b != '0) |=>
        (!result_ready_pulse [*2]) ##[1:16] result_ready_pulse)
        else $error("divide iteration count out of range");
    mul_overflow_a: assert property (result_ready_pulse && !op_div |->
        overflow_flag == (result_high != {OP_W{result_low[OP_W-1]}}))
        else $error("multiply overflow flag wrong");
    rem_sign_a: assert property (result_ready_pulse && op_div && !overflow_flag && result_high != '0 |->
        result_high[OP_W-1] == a_neg)
        else $error("remainder sign wrong");
    ready_single_a: assert property (result_ready_pulse |=> !result_ready_pulse && !busy)
        else $error("ready not a single pulse before idle");
    busy_start_a: assert property ((take_mul_s or take_div_s) |=> busy)
        else $error("busy not raised after start");
    idle_quiet_a: assert property (!busy && !start_multiply && !start_divide |=> !busy && !result_ready_pulse)
        else $error("left idle without start");
    results_stand_a: assert property (!result_ready_pulse |->
        $stable({result_high, result_low, overflow_flag}))
        else $error("results changed outside ready");
endmodule

bind rmd_mul_div rmd_mul_div_sva chk (.sys_clk(sys_clk), .reset(reset), .start_multiply(start_multiply),
    .start_divide(start_divide), .operand_a(operand_a), .operand_b(operand_b), .result_high(result_high),
    .result_low(result_low), .overflow_flag(overflow_flag), .result_ready_pulse(result_ready_pulse), .busy(busy));

`default_nettype wire

// ---- sim/rmd_mul_div_bench.sv ----
// self-checking bench: directed and random multiply/divide traffic through the host model
`timescale 1ns/1ns
`default_nettype none

module rmd_mul_div_bench
    import rmd_pkg::*;
;
    typedef struct packed {
        logic [OP_W-1:0] hi;
        logic [OP_W-1:0] lo;
        logic            ovf;
        logic [7:0]      lat;
    } rmd_exp_s;

    logic            sys_clk = 1'b0;
    logic            reset   = 1'b1;
    logic            go      = 1'b0;
    logic            is_div  = 1'b0;
    logic [OP_W-1:0] a_in    = '0;
    logic [OP_W-1:0] b_in    = '0;
    logic            start_multiply, start_divide, overflow_flag, result_ready_pulse, busy;
    logic [OP_W-1:0] operand_a, operand_b, result_high, result_low;
    logic [31:0]     rnd     = 32'h0000a7b2;
    logic [31:0]     r;
    int              mismatches = 0;
    int              n_checks   = 0;
    int              cyc = 0;
    int              t0  = 0;
    rmd_exp_s        q[$];
    rmd_exp_s        e;
    // op bit, dividend or multiplier, divisor or multiplicand
    localparam logic [64:0] TBL [17] = '{
        65'h0_00000000_00000005, 65'h0_00000003_00000005, 65'h0_ffffffff_ffffffff,
        65'h0_7fffffff_7fffffff, 65'h0_80000000_80000000, 65'h0_00010000_00008000,
        65'h0_00010000_ffff8000, 65'h0_fffffffd_00000007, 65'h1_00000037_00000005,
        65'h1_fffffff9_00000002, 65'h1_00000007_fffffffe, 65'h1_12345678_00000001,
        65'h1_00000005_00000000, 65'h1_80000000_ffffffff, 65'h1_7fffffff_40000000,
        65'h1_fffffff0_80000000, 65'h1_00000003_00000007};

    always #4 sys_clk = ~sys_clk;

    rmd_host_model host (.sys_clk(sys_clk), .reset(reset), .go(go), .is_div(is_div), .a_in(a_in), .b_in(b_in),
        .busy(busy), .start_multiply(start_multiply), .start_divide(start_divide),
        .operand_a(operand_a), .operand_b(operand_b));
    rmd_mul_div uut (.sys_clk(sys_clk), .reset(reset), .start_multiply(start_multiply),
        .start_divide(start_divide), .operand_a(operand_a), .operand_b(operand_b), .result_high(result_high),
        .result_low(result_low), .overflow_flag(overflow_flag), .result_ready_pulse(result_ready_pulse), .busy(busy));

    function automatic logic [31:0] nxt();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    function automatic rmd_exp_s expect_of(input logic d, input logic [OP_W-1:0] a, input logic [OP_W-1:0] b);
        rmd_exp_s x;
        longint   sa;
        longint   sb;
        longint   pr;
        int       p;
        sa = longint'(signed'(a));
        sb = longint'(signed'(b));
        x = '0;
        p = 0;
        if (!d) begin
            pr    = sa * sb;
            x.hi  = pr[63:32];
            x.lo  = pr[31:0];
            x.ovf = (pr[63:31] != '0) && (pr[63:31] != '1);
            x.lat = 8'h22;
        end else if (b == '0) begin
            x.ovf = 1'b1;
            x.lat = 8'h01;
        end else begin
            pr   = sa / sb;
            x.lo = pr[31:0];
            pr   = sa % sb;
            x.hi = pr[31:0];
            pr   = (sb < 0) ? -sb : sb;
            for (int i = 0; i < 32; i++) if (pr[i]) p = i;
            // loop of 16 - p/2 passes, then remainder fix, then ready
            x.lat = 8'(18 - p / 2);
        end
        return x;
    endfunction

    task automatic send(input logic d, input logic [OP_W-1:0] a, input logic [OP_W-1:0] b);
        q.push_back(expect_of(d, a, b));
        go     <= 1'b1;
        is_div <= d;
        a_in   <= a;
        b_in   <= b;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask

    task automatic drain();
        for (int i = 0; i < 120 && q.size() != 0; i++) @(posedge sys_clk);
        // a result that never shows must not slip through to the verdict
        if (q.size() != 0) begin
            mismatches++;
            $display("wrong value at %0t: result never arrived", $time);
            q.delete();
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // sampled mid-cycle so pops never race the driver
    always @(negedge sys_clk) begin
        cyc++;
        if (!reset && !busy && (start_multiply || start_divide)) t0 = cyc;
        if (result_ready_pulse === 1'b1) begin
            if (q.size() == 0) begin
                mismatches++;
                $display("wrong value at %0t: ready with nothing pending", $time);
            end else begin
                e = q.pop_front();
                n_checks += 2;
                if (result_high !== e.hi || result_low !== e.lo || overflow_flag !== e.ovf) begin
                    mismatches++;
                    $display("wrong value at %0t: got %h %h %b want %h %h %b", $time,
                        result_high, result_low, overflow_flag, e.hi, e.lo, e.ovf);
                end
                if (cyc - t0 != int'(e.lat)) begin
                    mismatches++;
                    $display("wrong value at %0t: latency %0d want %0d", $time, cyc - t0, e.lat);
                end
            end
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 17; i++) begin
            send(TBL[i][64], TBL[i][63:32], TBL[i][31:0]);
            drain();
        end
        $display("test directed done");
        // second start arrives while busy and must wait for idle
        send(1'b0, 32'hfffffffd, 32'h00000007);
        @(posedge sys_clk);
        send(1'b1, 32'h00000064, 32'h00000007);
        drain();
        $display("test refused start done");
        for (int i = 0; i < 60; i++) begin
            r = nxt();
            send(r[0], nxt(), nxt() >> r[5:1]);
            drain();
        end
        $display("test random done");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("wrong value at %0t: run timed out", $time);
        test_done();
    end
endmodule

`default_nettype wire
